//--- logic/rpf_buf_mem.sv
// Purpose: Byte store for the data section of a received request.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data always comes from a register, one cycle late.
module rpf_buf_mem
  import rpf_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  wr_en,
  input  wire logic [RPF_ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]            wr_data,
  input  wire logic [RPF_ADDR_W-1:0] rd_addr,
  output logic      [7:0]            rd_data
);

  logic [7:0] mem [RPF_DATA_MAX];

  // ----------------------------------------------------------------
  // Storage, no reset so it maps onto block memory
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : rpf_buf_mem

//--- logic/rpf_framer.sv
// Purpose: Parses request frames and builds response frames.
// Assumes: rx and tx byte streams run on mclk; engine on mclk.
// Notes:   One request outstanding at a time.
module rpf_framer
  import rpf_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_byte,
  input  wire logic                  tx_ready,
  output logic                       tx_valid,
  output logic      [7:0]            tx_byte,
  output logic                       req_valid,
  output logic      [15:0]           req_node,
  output logic      [7:0]            req_flags,
  output logic      [7:0]            req_cmd,
  output logic      [8:0]            req_dlen,
  output logic                       mod_full,
  output logic                       coding_1of4,
  output logic                       req_pending,
  input  wire logic [RPF_ADDR_W-1:0] req_rd_addr,
  output logic      [7:0]            req_rd_data,
  input  wire logic                  rsp_start,
  input  wire logic                  rsp_silent,
  input  wire logic [1:0]            rsp_err_sel,
  input  wire logic [8:0]            rsp_dlen,
  input  wire logic                  rsp_dvalid,
  input  wire logic [7:0]            rsp_dbyte,
  output logic                       rsp_dtake
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // Async assert, two-flop release to avoid recovery hazards
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Maps the engine's error select onto a code
  function automatic logic [7:0] err_code(input logic [1:0] sel);
    case (sel)
      2'd1:    err_code = RPF_ERR_NOTAG;
      2'd2:    err_code = RPF_ERR_NOSUP;
      default: err_code = RPF_ERR_FLAGS;
    endcase
  endfunction : err_code

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  rpf_rx_st_t  r_state_reg, r_state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] len_reg, len_next;
  logic [15:0] node_reg, node_next;
  logic [7:0]  flags_reg, flags_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [7:0]  cfg_reg, cfg_next;
  logic        ck_ok_reg, ck_ok_next;
  logic        req_fire;
  logic        rx_load, rx_en, wr_en;
  logic [7:0]  rx_acc;
  logic [15:0] len_full;

  assign len_full = {rx_byte, len_reg[7:0]};
  // Data bytes go to the store from position 7 on
  assign wr_en = rx_valid && (r_state_reg == RPF_R_BODY)
                 && (cnt_reg >= RPF_POS_DATA);

  // Frame parser
  always_comb begin
    r_state_next = r_state_reg;
    cnt_next     = cnt_reg;
    len_next     = len_reg;
    node_next    = node_reg;
    flags_next   = flags_reg;
    cmd_next     = cmd_reg;
    cfg_next     = cfg_reg;
    ck_ok_next   = ck_ok_reg;
    req_fire     = 1'b0;
    rx_load      = 1'b0;
    rx_en        = 1'b0;
    if (rx_valid) begin
      cnt_next = cnt_reg + 16'h0001;
      case (r_state_reg)
        RPF_R_IDLE: begin
          // Busy hides new frames until the answer is out
          if (rx_byte == RPF_SOP && !req_pending) begin
            r_state_next = RPF_R_LENL;
            cnt_next     = 16'h0001;
            cfg_next     = 8'h00;
            rx_load      = 1'b1;
          end
        end
        RPF_R_LENL: begin
          len_next     = {8'h00, rx_byte};
          rx_en        = 1'b1;
          r_state_next = RPF_R_LENH;
        end
        RPF_R_LENH: begin
          len_next = len_full;
          rx_en    = 1'b1;
          if (len_full < RPF_OVERHEAD || len_full > RPF_LEN_MAX) begin
            r_state_next = RPF_R_IDLE;
          end else begin
            r_state_next = RPF_R_BODY;
          end
        end
        RPF_R_BODY: begin
          rx_en = 1'b1;
          if (cnt_reg == RPF_POS_NODEL) begin
            node_next[7:0] = rx_byte;
          end else if (cnt_reg == RPF_POS_NODEH) begin
            node_next[15:8] = rx_byte;
          end else if (cnt_reg == RPF_POS_FLAGS) begin
            flags_next = rx_byte;
          end else if (cnt_reg == RPF_POS_CMD) begin
            cmd_next = rx_byte;
          end else if (cnt_reg == RPF_POS_DATA) begin
            cfg_next = rx_byte;
          end
          if (cnt_reg == len_reg - RPF_TAIL) begin
            r_state_next = RPF_R_CK1;
          end
        end
        RPF_R_CK1: begin
          ck_ok_next   = (rx_byte == rx_acc);
          r_state_next = RPF_R_CK2;
        end
        default: begin
          // Sender's second check byte must be the complement
          req_fire     = ck_ok_reg
                         && (rx_byte == (rx_acc ^ RPF_CK2_MASK));
          r_state_next = RPF_R_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_state_reg <= RPF_R_IDLE;
      cnt_reg     <= 16'h0000;
      len_reg     <= 16'h0000;
      node_reg    <= 16'h0000;
      flags_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      cfg_reg     <= 8'h00;
      ck_ok_reg   <= 1'b0;
    end else begin
      r_state_reg <= r_state_next;
      cnt_reg     <= cnt_next;
      len_reg     <= len_next;
      node_reg    <= node_next;
      flags_reg   <= flags_next;
      cmd_reg     <= cmd_next;
      cfg_reg     <= cfg_next;
      ck_ok_reg   <= ck_ok_next;
    end
  end

  // Request hand-off to the engine, only on a clean frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_valid   <= 1'b0;
      req_node    <= 16'h0000;
      req_flags   <= 8'h00;
      req_cmd     <= 8'h00;
      req_dlen    <= 9'h000;
      mod_full    <= 1'b0;
      coding_1of4 <= 1'b0;
    end else begin
      req_valid <= req_fire;
      if (req_fire) begin
        req_node    <= node_reg;
        req_flags   <= flags_reg;
        req_cmd     <= cmd_reg;
        req_dlen    <= 9'(len_reg - RPF_OVERHEAD);
        mod_full    <= cfg_reg[RPF_CFG_MOD];
        coding_1of4 <= cfg_reg[RPF_CFG_CODE];
      end
    end
  end

  rpf_xor_acc u_rx_acc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (rx_load),
    .en    (rx_en),
    .din   (rx_byte),
    .acc   (rx_acc)
  );

  rpf_buf_mem u_buf (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_en),
    .wr_addr (RPF_ADDR_W'(cnt_reg - RPF_POS_DATA)),
    .wr_data (rx_byte),
    .rd_addr (req_rd_addr),
    .rd_data (req_rd_data)
  );

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  rpf_tx_st_t  t_state_reg, t_state_next;
  logic [2:0]  idx_reg, idx_next;
  logic [8:0]  dcnt_reg, dcnt_next;
  logic [8:0]  tdlen_reg, tdlen_next;
  logic [1:0]  esel_reg, esel_next;
  logic        tx_valid_next, rsp_dtake_next, busy_next;
  logic [7:0]  tx_byte_next, hdr, tx_acc;
  logic [15:0] plen;
  logic        tx_free, tx_load, tx_en;

  assign tx_free = !tx_valid || tx_ready;
  assign plen    = 16'(RPF_OVERHEAD + {7'h00, tdlen_reg});

  // Header byte for the current position
  always_comb begin
    case (idx_reg)
      3'd0:    hdr = RPF_SOP;
      3'd1:    hdr = plen[7:0];
      3'd2:    hdr = plen[15:8];
      3'd3:    hdr = req_node[7:0];
      3'd4:    hdr = req_node[15:8];
      // Only the error bit is used, the rest stay reserved
      3'd5:    hdr = RPF_FLAGS_RST
                     | {3'b000, (esel_reg != 2'd0), 4'h0};
      default: hdr = req_cmd;
    endcase
  end

  // Response builder with stall on tx_ready
  always_comb begin
    t_state_next   = t_state_reg;
    idx_next       = idx_reg;
    dcnt_next      = dcnt_reg;
    tdlen_next     = tdlen_reg;
    esel_next      = esel_reg;
    tx_byte_next   = tx_byte;
    tx_valid_next  = tx_valid && !tx_ready;
    rsp_dtake_next = 1'b0;
    busy_next      = req_pending || req_fire;
    tx_load        = 1'b0;
    tx_en          = 1'b0;
    case (t_state_reg)
      RPF_T_IDLE: begin
        // Start is ignored unless a request is waiting
        if (rsp_start && req_pending) begin
          if (rsp_silent) begin
            busy_next = 1'b0;
          end else begin
            esel_next    = rsp_err_sel;
            tdlen_next   = (rsp_err_sel != 2'd0) ? 9'h001 : rsp_dlen;
            idx_next     = 3'd0;
            t_state_next = RPF_T_HEAD;
          end
        end
      end
      RPF_T_HEAD: begin
        if (tx_free) begin
          tx_byte_next  = hdr;
          tx_valid_next = 1'b1;
          tx_load       = (idx_reg == 3'd0);
          tx_en         = (idx_reg != 3'd0);
          idx_next      = idx_reg + 3'd1;
          if (idx_reg == 3'd6) begin
            dcnt_next    = tdlen_reg;
            t_state_next = (tdlen_reg == 9'h000) ? RPF_T_CK1
                                                 : RPF_T_DATA;
          end
        end
      end
      RPF_T_DATA: begin
        if (tx_free) begin
          if (esel_reg != 2'd0) begin
            tx_byte_next  = err_code(esel_reg);
            tx_valid_next = 1'b1;
            tx_en         = 1'b1;
            dcnt_next     = dcnt_reg - 9'h001;
          end else if (rsp_dvalid && !rsp_dtake) begin
            // Engine bytes pass as-is, inventory included
            tx_byte_next   = rsp_dbyte;
            tx_valid_next  = 1'b1;
            tx_en          = 1'b1;
            rsp_dtake_next = 1'b1;
            dcnt_next      = dcnt_reg - 9'h001;
          end
          if (tx_en && dcnt_reg == 9'h001) begin
            t_state_next = RPF_T_CK1;
          end
        end
      end
      RPF_T_CK1: begin
        if (tx_free) begin
          tx_byte_next  = tx_acc;
          tx_valid_next = 1'b1;
          t_state_next  = RPF_T_CK2;
        end
      end
      RPF_T_CK2: begin
        if (tx_free) begin
          tx_byte_next  = tx_acc ^ RPF_CK2_MASK;
          tx_valid_next = 1'b1;
          t_state_next  = RPF_T_DRAIN;
        end
      end
      default: begin
        if (tx_free) begin
          busy_next    = 1'b0;
          t_state_next = RPF_T_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_reg <= RPF_T_IDLE;
      idx_reg     <= 3'd0;
      dcnt_reg    <= 9'h000;
      tdlen_reg   <= 9'h000;
      esel_reg    <= 2'd0;
      tx_byte     <= 8'h00;
      tx_valid    <= 1'b0;
      rsp_dtake   <= 1'b0;
      req_pending <= 1'b0;
    end else begin
      t_state_reg <= t_state_next;
      idx_reg     <= idx_next;
      dcnt_reg    <= dcnt_next;
      tdlen_reg   <= tdlen_next;
      esel_reg    <= esel_next;
      tx_byte     <= tx_byte_next;
      tx_valid    <= tx_valid_next;
      rsp_dtake   <= rsp_dtake_next;
      req_pending <= busy_next;
    end
  end

  rpf_xor_acc u_tx_acc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (tx_load),
    .en    (tx_en),
    .din   (tx_byte_next),
    .acc   (tx_acc)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TX_SOP: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_HEAD && idx_reg == 3'd0 && tx_free)
    |=> (tx_valid && tx_byte == RPF_SOP))
    else $error("response does not open with start byte");

  AST_CK1: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_CK1 && tx_free) |=> tx_byte == $past(tx_acc))
    else $error("first check byte wrong");

  AST_CK2: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_CK2 && tx_free)
    |=> tx_byte == ($past(tx_byte) ^ 8'hff))
    else $error("second check byte is not the complement");

  AST_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_HEAD && idx_reg == 3'd5 && tx_free)
    |=> tx_byte == {3'b000, $past(esel_reg) != 2'd0, 4'h0})
    else $error("response flags byte wrong");

  AST_ECHO: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_HEAD && idx_reg == 3'd6 && tx_free)
    |=> tx_byte == req_cmd)
    else $error("command code not echoed");

  AST_ERRB: assert property (@(posedge mclk) disable iff (!rst_n)
    (t_state_reg == RPF_T_DATA && esel_reg == 2'd2 && tx_free)
    |=> (tx_byte == 8'h02 && t_state_reg == RPF_T_CK1))
    else $error("error byte missing or wrong");

  AST_NOUNSOL: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(tx_valid) |-> $past(req_pending))
    else $error("response sent without a request");

  AST_GOODREQ: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |-> ($past(r_state_reg) == RPF_R_CK2 && $past(ck_ok_reg)
                   && req_pending))
    else $error("request passed without checks");

  AST_BADLEN: assert property (@(posedge mclk) disable iff (!rst_n)
    // A start byte may follow at once, so only LENH is ruled out after
    (r_state_reg == RPF_R_LENH && rx_valid
     && (len_full < RPF_OVERHEAD || len_full > RPF_LEN_MAX))
    |=> r_state_reg == RPF_R_IDLE ##1 r_state_reg != RPF_R_LENH)
    else $error("bad length not dropped");

  AST_CFG: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |-> (mod_full == $past(cfg_reg[4])
                   && coding_1of4 == $past(cfg_reg[0])))
    else $error("config bits not decoded");

endmodule : rpf_framer

//--- logic/rpf_pkg.sv
// Purpose: Shared constants and state types of the pass-through framer.
// Assumes: Byte stream from a serial receiver on the same clock.
// Notes:   The frame layout numbers live here; the transmit header and the bench repeat some as literals.
package rpf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  RPF_SOP       = 8'h01;
  localparam logic [7:0]  RPF_CMD_ISO   = 8'h60;
  localparam logic [7:0]  RPF_CK2_MASK  = 8'hff;
  localparam logic [15:0] RPF_OVERHEAD  = 16'h0009;
  localparam logic [15:0] RPF_LEN_MAX   = 16'h0109;
  localparam logic [15:0] RPF_POS_NODEL = 16'h0003;
  localparam logic [15:0] RPF_POS_NODEH = 16'h0004;
  localparam logic [15:0] RPF_POS_FLAGS = 16'h0005;
  localparam logic [15:0] RPF_POS_CMD   = 16'h0006;
  localparam logic [15:0] RPF_POS_DATA  = 16'h0007;
  localparam logic [15:0] RPF_TAIL      = 16'h0003;
  localparam int          RPF_DATA_MAX  = 256;
  localparam int          RPF_ADDR_W    = 8;

  // ----------------------------------------------------------------
  // Field bits and codes
  // ----------------------------------------------------------------
  localparam int          RPF_FLAG_ERR  = 4;
  localparam int          RPF_CFG_MOD   = 4;
  localparam int          RPF_CFG_CODE  = 0;
  localparam logic [7:0]  RPF_FLAGS_RST = 8'h00;
  localparam logic [7:0]  RPF_ERR_NOTAG = 8'h01;
  localparam logic [7:0]  RPF_ERR_NOSUP = 8'h02;
  localparam logic [7:0]  RPF_ERR_FLAGS = 8'h04;

  typedef enum logic [2:0] {
    RPF_R_IDLE, RPF_R_LENL, RPF_R_LENH, RPF_R_BODY, RPF_R_CK1, RPF_R_CK2
  } rpf_rx_st_t;

  typedef enum logic [2:0] {
    RPF_T_IDLE, RPF_T_HEAD, RPF_T_DATA, RPF_T_CK1, RPF_T_CK2, RPF_T_DRAIN
  } rpf_tx_st_t;

endpackage : rpf_pkg

//--- logic/rpf_xor_acc.sv
// Purpose: Running XOR of frame bytes for check byte work.
// Assumes: load starts a new frame with its first byte.
// Notes:   load wins over en when both are high.
module rpf_xor_acc (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic       en,
  input  wire logic [7:0] din,
  output logic      [7:0] acc
);

  logic [7:0] acc_next;

  // Next sum
  always_comb begin
    acc_next = acc;
    if (load) begin
      acc_next = din;
    end else if (en) begin
      acc_next = acc ^ din;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 8'h00;
    end else begin
      acc <= acc_next;
    end
  end

endmodule : rpf_xor_acc

//--- test/rpf_host_model.sv
// Purpose: Host side of the serial link for the framer bench.
// Assumes: Bytes move on mclk, one per edge at most.
// Notes:   A slow host is ready for a response byte on every other edge only.
module rpf_host_model
  import rpf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       stall,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got_q[$];

  // Quiet line at time zero
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h5a;
  end

  // Collect response bytes on the handshake edge
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) got_q.push_back(tx_byte);
    tx_ready <= stall ? ~tx_ready : 1'b1;
  end

  // One byte per edge, back to back when called in a row
  task send_byte(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_byte  <= b;
  endtask : send_byte

  // Released line shows the inverse so stale data never matches
  task idle();
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_byte  <= ~rx_byte;
  endtask : idle
endmodule : rpf_host_model

//--- test/tb_rpf_framer.sv
// Purpose: Self-checking bench of the pass-through framer.
// Assumes: Engine side driven here, host side by the model.
// Notes:   Expected frames are built here from the layout.
module tb_rpf_framer
  import rpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Design and host
  // ------------------------------------------------------------
  logic        mclk, arst_n, stall, rx_valid, tx_ready, tx_valid;
  logic        req_valid, mod_full, coding_1of4, req_pending;
  logic        rsp_start, rsp_silent, rsp_dvalid, rsp_dtake;
  logic [7:0]  rx_byte, tx_byte, req_flags, req_cmd, req_rd_data;
  logic [7:0]  rsp_dbyte;
  logic [RPF_ADDR_W-1:0] req_rd_addr;
  logic [15:0] req_node, node;
  logic [8:0]  req_dlen, rsp_dlen;
  logic [1:0]  rsp_err_sel;
  logic [7:0]  dat[0:7];
  logic [7:0]  exp_q[$];
  int          n_fail, total_checks, idx;
  int          cyc = 0;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  rpf_framer dut_u (.mclk(mclk), .arst_n(arst_n), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .req_valid(req_valid), .req_node(req_node),
    .req_flags(req_flags), .req_cmd(req_cmd), .req_dlen(req_dlen),
    .mod_full(mod_full), .coding_1of4(coding_1of4),
    .req_pending(req_pending), .req_rd_addr(req_rd_addr),
    .req_rd_data(req_rd_data), .rsp_start(rsp_start),
    .rsp_silent(rsp_silent), .rsp_err_sel(rsp_err_sel),
    .rsp_dlen(rsp_dlen), .rsp_dvalid(rsp_dvalid),
    .rsp_dbyte(rsp_dbyte), .rsp_dtake(rsp_dtake));

  rpf_host_model host_u (.mclk(mclk), .stall(stall), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte));

  // Engine presents the next byte right after each take
  always @(posedge mclk) begin
    if (rsp_start) begin
      idx       <= 1;
      rsp_dbyte <= dat[0];
    end else if (rsp_dtake) begin
      idx       <= idx + 1;
      rsp_dbyte <= dat[idx];
    end
  end

  // Hang guard, well above the longest scenario
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk

  // Frame image; length counts both check bytes
  task mk(input logic [7:0] fl, input int n, input logic [7:0] bad);
    logic [7:0]  ck;
    logic [15:0] len;
    len   = 16'h0009 + 16'(n);
    exp_q = {8'h01, len[7:0], len[15:8], node[7:0], node[15:8], fl, 8'h60};
    for (int i = 0; i < n; i++) exp_q.push_back(dat[i]);
    ck = 8'h00;
    foreach (exp_q[j]) ck ^= exp_q[j];
    exp_q.push_back(ck ^ bad);
    exp_q.push_back(ck ^ 8'hff);
  endtask : mk

  task send();
    foreach (exp_q[j]) host_u.send_byte(exp_q[j]);
    host_u.idle();
  endtask : send

  task t_req(input logic [15:0] nd, input logic [7:0] cfg);
    int i;
    node   = nd;
    dat[0] = cfg;
    for (i = 1; i < 4; i++) dat[i] = nd[7:0] + 8'(i);
    mk(8'h02, 4, 8'h00); // flags, code 60, no SOF/CRC
    host_u.send_byte(8'h33); // stray byte ahead
    send();
    for (i = 0; i < 40 && req_valid !== 1'b1; i++) @(negedge mclk);
    chk(req_valid, 1'b1);
    chk(req_node, nd);
    chk(req_flags, 8'h02);
    chk(req_cmd, 8'h60);
    chk(req_dlen, 9'h004);
    chk(mod_full, cfg[4]);
    chk(coding_1of4, cfg[0]);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      req_rd_addr <= 8'(i);
      @(posedge mclk);
      @(negedge mclk);
      chk(req_rd_data, dat[i]);
    end
  endtask : t_req

  task t_drop();
    node   = 16'h0203;
    dat[0] = 8'h10;
    dat[1] = 8'h20;
    mk(8'h00, 2, 8'h40); // first check byte wrong
    send();
    mk(8'h00, 2, 8'h00);
    exp_q[exp_q.size()-1] ^= 8'h01; // second check byte wrong
    send();
    exp_q = {8'h01, 8'h05, 8'h00, 8'h22}; // length below minimum
    send();
    repeat (30) begin
      @(negedge mclk);
      chk({req_valid, req_pending}, 2'h0);
    end
  endtask : t_drop

  task t_rsp(input logic [1:0] e, input int n);
    int i;
    host_u.got_q.delete();
    for (i = 0; i < n; i++) dat[i] = 8'hc0 + 8'(i);
    @(posedge mclk);
    rsp_start   <= 1'b1;
    rsp_err_sel <= e;
    rsp_dlen    <= 9'(n);
    rsp_dvalid  <= 1'b1;
    @(posedge mclk);
    rsp_start <= 1'b0;
    for (i = 0; i < 300 && req_pending !== 1'b0; i++) @(negedge mclk);
    @(posedge mclk);
    rsp_dvalid <= 1'b0;
    // Error frames carry just the code, engine data stays unused
    if (e != 2'h0) begin
      dat[0] = (e == 2'h3) ? 8'h04 : {6'h00, e};
    end
    // Flags bit 4 only on error, command echoed as 60
    mk((e != 2'h0) ? 8'h10 : 8'h00,
       (e != 2'h0) ? 1 : n, 8'h00);
    // Engine takes counted by the bench's engine index
    chk(16'(idx - 1), (e != 2'h0) ? 16'h0 : 16'(n));
    chk(host_u.got_q.size(), exp_q.size());
    foreach (exp_q[j]) begin
      chk(host_u.got_q[j], exp_q[j]);
    end
  endtask : t_rsp

  // Start with nothing owed, or with the silent flag
  task t_quiet(input logic silent);
    host_u.got_q.delete();
    @(posedge mclk);
    rsp_start  <= 1'b1;
    rsp_silent <= silent;
    @(posedge mclk);
    rsp_start  <= 1'b0;
    rsp_silent <= 1'b0;
    repeat (40) @(negedge mclk);
    chk(req_pending, 1'b0);
    chk(host_u.got_q.size(), 0);
  endtask : t_quiet

  task finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Next request only after each answer
  initial begin
    arst_n       = 1'b0;
    stall        = 1'b0;
    req_rd_addr  = '0;
    rsp_start    = 1'b0;
    rsp_silent   = 1'b0;
    rsp_err_sel  = 2'h0;
    rsp_dlen     = 9'h000;
    rsp_dvalid   = 1'b0;
    rsp_dbyte    = 8'h00;
    n_fail       = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({tx_valid, req_valid, req_pending}, 3'h0);
    t_quiet(1'b0);
    t_drop();
    t_req(16'h1234, 8'h11);
    stall <= 1'b1;
    t_rsp(2'h0, 3);
    stall <= 1'b0;
    t_req(16'hbe07, 8'h00);
    t_rsp(2'h0, 0);
    for (int e = 1; e < 4; e++) begin
      t_req(16'h0a50 + 16'(e), 8'h10);
      t_rsp(2'(e), 2);
    end
    t_req(16'h0304, 8'h01);
    t_quiet(1'b1);
    finish_test();
  end
endmodule : tb_rpf_framer
